// ### dbg_bus_model.sv
// system bus responder for debug memory commands
// assumes busReq is held until busAck, on the same clk
`timescale 1ns/100ps
module dbg_bus_model (
  // clock
  input wire logic clk,
  // bus
  input wire logic busReq,
  input wire logic [31:0] busAddr,
  output logic busAck,
  output logic [31:0] busRdata,
  // wait states before the answer
  input wire logic [1:0] lag
);
  logic [1:0] cnt = 2'h0;
  initial busAck = 1'b0;
  initial busRdata = 32'h0;
  always @(posedge clk) begin
    busAck <= 1'b0;
    // toggling filler while no answer is given
    busRdata <= ~busRdata;
    if (busReq && !busAck) begin
      if (cnt == lag) begin
        cnt <= 2'h0;
        busAck <= 1'b1;
        busRdata <= busAddr ^ 32'h5A5A5A5A;
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// ### dbg_cmd_if.sv
// carrier between the breakpoint register file and the breakpoint comparator
// assumes both ends share clk
`timescale 1ns/100ps
interface dbg_cmd_if;
  logic [31:0] pcAddr [4];
  logic [3:0] pcEnable;
  logic [31:0] pcMask;
  logic [3:0] matchVec;
  modport ctrl (output pcAddr, output pcEnable, output pcMask, input matchVec);
  modport cmp (input pcAddr, input pcEnable, input pcMask, output matchVec);
endinterface

// ### dbg_pkg.sv
// shared constants and types for the debug breakpoint block
// assumes a single 100 MHz clock domain
package dbg_pkg;

  // ************************************************************
  // debug register codes
  // ************************************************************
  localparam logic [4:0] CODE_ATTR = 5'h05;
  localparam logic [4:0] CODE_PCB0 = 5'h08;
  localparam logic [4:0] CODE_PCMASK = 5'h09;
  localparam logic [4:0] CODE_BKCTRL = 5'h07;
  localparam logic [4:0] CODE_PCB1 = 5'h18;
  localparam logic [4:0] CODE_PCB2 = 5'h1A;
  localparam logic [4:0] CODE_PCB3 = 5'h1B;

  // ************************************************************
  // widths and reset values
  // ************************************************************
  localparam int ATTR_W = 8;
  localparam int NUM_PCB = 4;
  localparam logic [7:0] ATTR_RESET = 8'h05;
  localparam logic [31:0] MASK_RESET = 32'hFFFFFFFF;
  localparam logic [3:0] BKCTRL_RESET = 4'h0;
  localparam logic [31:0] PCB_RESET = 32'h00000000;

  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int BK_EN_LO = 0;
  localparam int BK_IRQ_BIT = 4;

  // ************************************************************
  // debug command states
  // ************************************************************
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_BUS = 2'b01,
    CMD_DONE = 2'b11
  } cmd_state_t;

endpackage

// ### debug_module_breakpoint_trace.sv
// debug module: pc breakpoints, debug memory command path, combined status
// assumes debugger writes arrive as one-cycle strobes on clk, bus answers with ack
`timescale 1ns/100ps
module debug_module_breakpoint_trace (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // debug register writes
  input wire logic regWrite,
  input wire logic [4:0] regCode,
  input wire logic [31:0] regData,
  // debug memory commands
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic memDone,
  output logic [31:0] memRdata,
  // system bus
  output logic busReq,
  output logic busWrite,
  output logic [31:0] busAddr,
  output logic [31:0] busWdata,
  output logic [7:0] busAttr,
  input wire logic busAck,
  input wire logic [31:0] busRdata,
  // core
  input wire logic [31:0] pc,
  input wire logic pcValid,
  input wire logic breakpointInput,
  output logic haltReq,
  output logic debugIrq,
  // trace
  input wire logic [3:0] processorStatusLines,
  output logic combinedStatusOutput
);

  // ************************************************************
  // breakpoint register file
  // ************************************************************
  dbg_cmd_if link ();
  logic [31:0] pcb_reg [4];
  logic [31:0] mask_reg;
  logic [3:0] bkctrl_reg;
  logic [7:0] attr_reg;

  wire logic wrAttr = regWrite && regCode == dbg_pkg::CODE_ATTR;
  wire logic wrMask = regWrite && regCode == dbg_pkg::CODE_PCMASK;
  wire logic wrCtrl = regWrite && regCode == dbg_pkg::CODE_BKCTRL;
  wire logic [3:0] wrPcb = {
    regWrite && regCode == dbg_pkg::CODE_PCB3,
    regWrite && regCode == dbg_pkg::CODE_PCB2,
    regWrite && regCode == dbg_pkg::CODE_PCB1,
    regWrite && regCode == dbg_pkg::CODE_PCB0};

  // enables in regData bits 3:0, irq option in bit 4 of the control word
  always_ff @(posedge clk) begin
    if (rst) begin
      attr_reg <= dbg_pkg::ATTR_RESET;
      mask_reg <= dbg_pkg::MASK_RESET;
      bkctrl_reg <= dbg_pkg::BKCTRL_RESET;
    end else begin
      if (wrAttr) attr_reg <= regData[7:0];
      if (wrMask) mask_reg <= regData;
      if (wrCtrl) bkctrl_reg <= regData[dbg_pkg::BK_EN_LO +: dbg_pkg::NUM_PCB];
    end
  end

  logic irqMode_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      irqMode_reg <= 1'b0;
    end else if (wrCtrl) begin
      irqMode_reg <= regData[dbg_pkg::BK_IRQ_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < dbg_pkg::NUM_PCB; g++) begin : gPcb
      always_ff @(posedge clk) begin
        if (rst) begin
          pcb_reg[g] <= dbg_pkg::PCB_RESET;
        end else if (wrPcb[g]) begin
          pcb_reg[g] <= regData;
        end
      end
      assign link.pcAddr[g] = pcb_reg[g];
    end
  endgenerate

  assign link.pcEnable = bkctrl_reg;
  assign link.pcMask = mask_reg;

  pc_match uMatch (
    .clk(clk),
    .rst(rst),
    .pc(pc),
    .pcValid(pcValid),
    .bus(link.cmp)
  );

  // ************************************************************
  // breakpoint input synchroniser and response
  // ************************************************************
  logic [2:0] bkSync_reg;
  logic bkLevel_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      bkSync_reg <= 3'b000;
      bkLevel_reg <= 1'b0;
    end else begin
      bkSync_reg <= {bkSync_reg[1:0], breakpointInput};
      if (bkSync_reg[2] == bkSync_reg[1]) bkLevel_reg <= bkSync_reg[1];
    end
  end

  wire logic extHit = bkLevel_reg;
  wire logic pcHit = |link.matchVec;
  wire logic irqPath = extHit && irqMode_reg;
  wire logic haltPath = pcHit || (extHit && !irqMode_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      haltReq <= 1'b0;
      debugIrq <= 1'b0;
    end else begin
      haltReq <= haltPath;
      debugIrq <= irqPath;
    end
  end

  // ************************************************************
  // combined status output
  // ************************************************************
  logic [2:0] statSync_reg [4];
  generate
    for (g = 0; g < 4; g++) begin : gStat
      always_ff @(posedge clk) begin
        if (rst) begin
          statSync_reg[g] <= 3'b000;
        end else begin
          statSync_reg[g] <= {statSync_reg[g][1:0], processorStatusLines[g]};
        end
      end
    end
  endgenerate

  wire logic statAgree = statSync_reg[0][2] == statSync_reg[0][1] && statSync_reg[1][2] == statSync_reg[1][1]
    && statSync_reg[2][2] == statSync_reg[2][1] && statSync_reg[3][2] == statSync_reg[3][1];
  wire logic statAnd = statSync_reg[0][1] & statSync_reg[1][1] & statSync_reg[2][1] & statSync_reg[3][1];

  always_ff @(posedge clk) begin
    if (rst) begin
      combinedStatusOutput <= 1'b0;
    end else if (statAgree) begin
      combinedStatusOutput <= statAnd;
    end
  end

  // ************************************************************
  // debug memory command sequencer
  // ************************************************************
  dbg_pkg::cmd_state_t state_reg;
  dbg_pkg::cmd_state_t state_next;
  logic [31:0] hiddenAddr_reg;
  // bus address is the hidden command address register
  assign busAddr = hiddenAddr_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dbg_pkg::CMD_IDLE: if (memReq) state_next = dbg_pkg::CMD_BUS;
      dbg_pkg::CMD_BUS: if (busAck) state_next = dbg_pkg::CMD_DONE;
      dbg_pkg::CMD_DONE: state_next = dbg_pkg::CMD_IDLE;
      default: state_next = dbg_pkg::CMD_IDLE;
    endcase
  end

  wire logic cmdStart = state_reg == dbg_pkg::CMD_IDLE && memReq;
  wire logic cmdFinish = state_reg == dbg_pkg::CMD_BUS && busAck;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= dbg_pkg::CMD_IDLE;
      hiddenAddr_reg <= 32'h00000000;
      busReq <= 1'b0;
      busWrite <= 1'b0;
      busWdata <= 32'h00000000;
      busAttr <= 8'h00;
      memDone <= 1'b0;
      memRdata <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      memDone <= cmdFinish;
      if (cmdStart) begin
        hiddenAddr_reg <= memAddr;
        busReq <= 1'b1;
        busWrite <= memWrite;
        busWdata <= memWdata;
        busAttr <= attr_reg;
      end else if (cmdFinish) begin
        busReq <= 1'b0;
        memRdata <= busWrite ? memRdata : busRdata;
      end
    end
  end

endmodule

// ### debug_module_breakpoint_trace_props.sv
// port checker for the debug breakpoint block
// assumes bound to the top module, single clk domain
`timescale 1ns/100ps
module debug_module_breakpoint_trace_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched signals
  input wire logic regWrite,
  input wire logic [4:0] regCode,
  input wire logic [31:0] regData,
  input wire logic [31:0] memAddr,
  input wire logic memDone,
  input wire logic busReq,
  input wire logic busAck,
  input wire logic [31:0] busAddr,
  input wire logic [7:0] busAttr,
  input wire logic breakpointInput,
  input wire logic haltReq,
  input wire logic debugIrq,
  input wire logic [3:0] processorStatusLines,
  input wire logic combinedStatusOutput
);
  logic [7:0] attr_reg;
  logic irqMode_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      attr_reg <= dbg_pkg::ATTR_RESET;
      irqMode_reg <= 1'b0;
    end else if (regWrite && regCode == dbg_pkg::CODE_ATTR) begin
      attr_reg <= regData[7:0];
    end else if (regWrite && regCode == dbg_pkg::CODE_BKCTRL) begin
      irqMode_reg <= regData[dbg_pkg::BK_IRQ_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_QUIET: assert property ($fell(rst) |-> !busReq && !memDone && !haltReq && !debugIrq)
    else $error("outputs active after reset");
  AST_ADDR_LOAD: assert property ($rose(busReq) |-> busAddr == $past(memAddr))
    else $error("bus address not loaded");
  AST_ATTR_USED: assert property (busReq |-> busAttr == attr_reg)
    else $error("bus attribute wrong");
  AST_BUS_HOLD: assert property (busReq && !busAck |=> busReq && $stable(busAddr) && $stable(busAttr))
    else $error("bus request dropped early");
  AST_DONE_AFTER_ACK: assert property (busReq && busAck |=> memDone && !busReq ##1 !memDone)
    else $error("done not one pulse after ack");
  AST_EXT_HALT: assert property (breakpointInput [*6] ##0 !irqMode_reg |-> haltReq && !debugIrq)
    else $error("pin did not halt");
  AST_EXT_IRQ: assert property (breakpointInput [*6] ##0 irqMode_reg |-> debugIrq)
    else $error("pin did not interrupt");
  AST_STATUS_HIGH: assert property ((&processorStatusLines) [*6] |-> combinedStatusOutput)
    else $error("status not high");
  AST_STATUS_LOW: assert property ((!(&processorStatusLines)) [*6] |-> !combinedStatusOutput)
    else $error("status not low");
endmodule
bind debug_module_breakpoint_trace debug_module_breakpoint_trace_props u_props (.clk, .rst, .regWrite,
  .regCode, .regData, .memAddr, .memDone, .busReq, .busAck, .busAddr, .busAttr, .breakpointInput, .haltReq,
  .debugIrq, .processorStatusLines, .combinedStatusOutput);

// ### pc_match.sv
// four program counter comparators, only entry zero masked
// assumes pc is the executing instruction address on the same clock
`timescale 1ns/100ps
module pc_match (
  // clock
  input wire logic clk,
  input wire logic rst,
  // instruction stream
  input wire logic [31:0] pc,
  input wire logic pcValid,
  // registers and result
  dbg_cmd_if.cmp bus
);

  // ************************************************************
  // comparators
  // ************************************************************
  logic [3:0] hit;
  logic [3:0] matchReg;
  genvar g;
  generate
    for (g = 0; g < dbg_pkg::NUM_PCB; g++) begin : gCmp
      if (g == 0) begin : gMasked
        assign hit[g] = ((pc ^ bus.pcAddr[g]) & bus.pcMask) == 32'h00000000;
      end else begin : gExact
        assign hit[g] = pc == bus.pcAddr[g];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      matchReg <= 4'h0;
    end else begin
      matchReg <= hit & bus.pcEnable & {4{pcValid}};
    end
  end

  assign bus.matchVec = matchReg;

endmodule

// ### test_debug_module_breakpoint_trace.sv
// self-checking bench for the debug breakpoint block
// assumes package, carrier, comparator, bus model and checker compiled first
`timescale 1ns/100ps
module test_debug_module_breakpoint_trace;
  logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, memReq = 1'b0, memWrite = 1'b0, pcValid = 1'b0;
  logic bkIn = 1'b0, memDone, busReq, busWrite, busAck, haltReq, debugIrq, allSt;
  logic [4:0] regCode = 5'h00;
  logic [31:0] regData = 32'h0, memAddr = 32'h0, memWdata = 32'h0, pc = 32'h0, lfsr = 32'h0DF9968F;
  logic [31:0] memRdata, busAddr, busWdata, busRdata, bp [4];
  logic [7:0] busAttr, attrExp = dbg_pkg::ATTR_RESET;
  logic [31:0] tmp;
  logic [3:0] st = 4'h0;
  logic [1:0] lag = 2'h0;
  int err_total = 0, n_checks = 0;
  always #5 clk = ~clk;
  debug_module_breakpoint_trace DUT (.clk, .rst, .regWrite, .regCode, .regData, .memReq, .memWrite, .memAddr,
    .memWdata, .memDone, .memRdata, .busReq, .busWrite, .busAddr, .busWdata, .busAttr, .busAck, .busRdata,
    .pc, .pcValid, .breakpointInput(bkIn), .haltReq, .debugIrq, .processorStatusLines(st),
    .combinedStatusOutput(allSt));
  dbg_bus_model partner (.clk, .busReq, .busAddr, .busAck, .busRdata, .lag);
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [31:0] rdExp(logic [31:0] a);
    return a ^ 32'h5A5A5A5A;
  endfunction
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [4:0] c, logic [31:0] d);
    regWrite = 1'b1;
    regCode = c;
    regData = d;
    tick(1);
    regWrite = 1'b0;
    tick(1);
  endtask
  task automatic mem(logic w, logic [31:0] a);
    int i;
    memReq = 1'b1;
    memWrite = w;
    memAddr = a;
    memWdata = rnd();
    for (i = 0; i < 20 && memDone !== 1'b1; i++) tick(1);
    memReq = 1'b0;
    if (i == 20) begin
      chk("memDone", 32'h1, 32'h0);
      tally_and_finish();
    end
    if (!w) chk("memRdata", rdExp(a), memRdata);
    chk("busAddr", a, busAddr);
    chk("busAttr", 32'(attrExp), 32'(busAttr));
    chk("busWrite", 32'(w), 32'(busWrite));
    if (w) chk("busWdata", memWdata, busWdata);
    tick(2);
  endtask
  task automatic pcs(logic [31:0] a, logic hit);
    pc = a;
    pcValid = 1'b1;
    tick(1);
    pcValid = 1'b0;
    tick(1);
    chk("haltReq", 32'(hit), 32'(haltReq));
    tick(2);
  endtask
  initial begin
    tick(6);
    rst = 1'b0;
    for (int k = 0; k < 6; k++) begin
      lag = 2'(k % 3);
      if (k > 0) begin
        tmp = rnd();
        attrExp = tmp[7:0];
        wr(dbg_pkg::CODE_ATTR, tmp);
      end
      mem(k[0], rnd());
    end
    for (int k = 0; k < 4; k++) bp[k] = rnd();
    wr(dbg_pkg::CODE_PCB0, bp[0]);
    wr(dbg_pkg::CODE_PCMASK, 32'hFFFFFF00);
    wr(dbg_pkg::CODE_PCB1, bp[1]);
    wr(dbg_pkg::CODE_PCB2, bp[2]);
    wr(dbg_pkg::CODE_PCB3, bp[3]);
    wr(dbg_pkg::CODE_BKCTRL, 32'h0000000F);
    wr(5'h15, rnd());
    mem(1'b0, bp[1]);
    pcs(bp[0] ^ 32'h0000003C, 1'b1);
    pcs(bp[0] ^ 32'h00000100, 1'b0);
    for (int k = 1; k < 4; k++) begin
      pcs(bp[k], 1'b1);
      pcs(bp[k] ^ 32'h00000001, 1'b0);
    end
    wr(dbg_pkg::CODE_BKCTRL, 32'h00000001);
    pcs(bp[1], 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(dbg_pkg::CODE_BKCTRL, {27'h0, k[0], 4'h0});
      bkIn = 1'b1;
      tick(8);
      chk("haltReq", 32'(!k[0]), 32'(haltReq));
      chk("debugIrq", 32'(k[0]), 32'(debugIrq));
      bkIn = 1'b0;
      tick(8);
    end
    for (int k = 0; k < 24; k++) begin
      st = k < 16 ? 4'(k) : 4'(rnd());
      tick(6);
      chk("allSt", 32'(&st), 32'(allSt));
    end
    tally_and_finish();
  end
endmodule
